// ### pwcg_top.sv
// Purpose: clock gating controls, port wake flags and wake pin of the power block
// Assumes: AHB-Lite single word transfers; PHY and host MAC events are levels
// Notes:   reads take one wait state, writes none; response always OKAY
`timescale 1ns/1ps
`include "pwcg_defs.svh"
module pwcg_top #(
    parameter int unsigned PULSE_CYCLES = `PWCG_PULSE_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // wake event sources
    input  wire logic        phy_a_event,
    input  wire logic        phy_b_event,
    input  wire logic        host_mac_wol_event,
    // clock enables to gated units
    output logic             time_unit_clk_en,
    output logic [2:0]       stamp_unit_clk_en,
    output logic             fabric_clk_en,
    output logic             host_mac_sysclk_en,
    output logic             host_mac_rxtx_clk_en,
    // wake event pin
    output logic             wake_event_pin,
    output logic             wake_event_pin_oe,
    // interrupt
    output logic             irq
);
    pwcg_gate_if gif ();

    // bus state
    logic                     wr_pend_r;
    logic                     rd_pend_r;
    logic [31:0]              addr_r;
    logic [31:0]              hrdata_r;
    logic [31:0]              rd_word;
    logic                     addr_ok;
    // write strobes
    logic                     wr_ctrl;
    logic                     wr_irq_en;
    logic                     wr_irq_clr;
    // control fields
    logic                     port_a_wake_flag_r;
    logic                     port_b_wake_flag_r;
    logic                     port_a_wake_en_r;
    logic                     port_b_wake_en_r;
    logic                     host_mac_wake_en_r;
    logic                     wake_pin_buffer_sel_r;
    logic                     wake_pin_style_r;
    logic                     wake_pin_polarity_r;
    logic                     wake_pin_en_r;
    // interrupt registers
    logic [`PWCG_IRQ_W-1:0]   irq_sts_r;
    logic [`PWCG_IRQ_W-1:0]   irq_en_r;
    logic [`PWCG_IRQ_W-1:0]   irq_set;
    // wake pin sequencer
    pwcg_pkg::pwcg_pulse_t    pulse_st_r;
    logic [`PWCG_CNT_W-1:0]   pulse_cnt_r;
    logic                     wake_cond;
    logic                     pin_active;
    logic                     pin_o_r;
    logic                     pin_oe_r;

    ////////////////////////////////////////////////////////////////////////////
    // address decode, used for reads and writes
    function automatic logic addr_is(input logic [31:0] a, input logic [31:0] off);
        addr_is = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave

    // address phase accepted on a valid selected transfer
    assign addr_ok = hsel & htrans[1] & hready;

    // hold the address for the data phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= `PWCG_WORD_ZERO;
        end else begin
            if (addr_ok) begin
                wr_pend_r <= hwrite;
                rd_pend_r <= ~hwrite;
                addr_r    <= haddr;
            end else if (hreadyout) begin
                wr_pend_r <= 1'b0;
            end
            if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
            end
        end
    end

    // one wait state on reads so read data sees any preceding write
    assign hreadyout = ~rd_pend_r;
    assign hresp     = `PWCG_HRESP_OKAY;
    assign hrdata    = hrdata_r;

    // write strobes in the write data phase
    assign wr_ctrl    = wr_pend_r & addr_is(addr_r, `PWCG_CTRL_ADDR);
    assign wr_irq_en  = wr_pend_r & addr_is(addr_r, `PWCG_IRQ_EN_ADDR);
    assign wr_irq_clr = wr_pend_r & addr_is(addr_r, `PWCG_IRQ_CLR_ADDR);

    // read mux; reserved and unmapped bits read zero
    always_comb begin
        rd_word = `PWCG_WORD_ZERO;
        if (addr_is(addr_r, `PWCG_CTRL_ADDR)) begin
            rd_word[`PWCG_B_TIME_OFF]   = gif.off[`PWCG_G_TIME];
            rd_word[`PWCG_B_STAMP2_OFF] = gif.off[`PWCG_G_STAMP2];
            rd_word[`PWCG_B_STAMP1_OFF] = gif.off[`PWCG_G_STAMP1];
            rd_word[`PWCG_B_STAMP0_OFF] = gif.off[`PWCG_G_STAMP0];
            rd_word[`PWCG_B_FABRIC_OFF] = gif.off[`PWCG_G_FABRIC];
            rd_word[`PWCG_B_HMAC_ALL]   = gif.off[`PWCG_G_HMAC_ALL];
            rd_word[`PWCG_B_HMAC_SYS]   = gif.off[`PWCG_G_HMAC_SYS];
            rd_word[`PWCG_B_B_FLAG]     = port_b_wake_flag_r;
            rd_word[`PWCG_B_A_FLAG]     = port_a_wake_flag_r;
            rd_word[`PWCG_B_B_EN]       = port_b_wake_en_r;
            rd_word[`PWCG_B_A_EN]       = port_a_wake_en_r;
            rd_word[`PWCG_B_HOST_MAC_WAKE_EN]     = host_mac_wake_en_r;
            rd_word[`PWCG_B_BUF_SEL]    = wake_pin_buffer_sel_r;
            rd_word[`PWCG_B_STYLE]      = wake_pin_style_r;
            rd_word[`PWCG_B_POL]        = wake_pin_polarity_r;
            rd_word[`PWCG_B_PIN_EN]     = wake_pin_en_r;
        end else if (addr_is(addr_r, `PWCG_IRQ_STS_ADDR)) begin
            rd_word[`PWCG_IRQ_W-1:0] = irq_sts_r;
        end else if (addr_is(addr_r, `PWCG_IRQ_EN_ADDR)) begin
            rd_word[`PWCG_IRQ_W-1:0] = irq_en_r;
        end
    end

    // read data captured in the wait cycle and held until the next read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hrdata_r <= `PWCG_WORD_ZERO;
        end else if (rd_pend_r) begin
            hrdata_r <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock-off bits through the two-write arming module

    assign gif.wr                    = wr_ctrl;
    assign gif.wbits[`PWCG_G_TIME]     = hwdata[`PWCG_B_TIME_OFF];
    assign gif.wbits[`PWCG_G_STAMP2]   = hwdata[`PWCG_B_STAMP2_OFF];
    assign gif.wbits[`PWCG_G_STAMP1]   = hwdata[`PWCG_B_STAMP1_OFF];
    assign gif.wbits[`PWCG_G_STAMP0]   = hwdata[`PWCG_B_STAMP0_OFF];
    assign gif.wbits[`PWCG_G_FABRIC]   = hwdata[`PWCG_B_FABRIC_OFF];
    assign gif.wbits[`PWCG_G_HMAC_ALL] = hwdata[`PWCG_B_HMAC_ALL];
    assign gif.wbits[`PWCG_G_HMAC_SYS] = hwdata[`PWCG_B_HMAC_SYS];

    pwcg_gate_arm u_arm (
        .clk     (clk),
        .sys_rst (sys_rst),
        .g       (gif.gate)
    );

    // clock enables from the gate bits
    assign time_unit_clk_en = ~gif.off[`PWCG_G_TIME];
    // a stamp unit also stops when the whole time unit is off
    assign stamp_unit_clk_en[2] = ~(gif.off[`PWCG_G_TIME] | gif.off[`PWCG_G_STAMP2]);
    assign stamp_unit_clk_en[1] = ~(gif.off[`PWCG_G_TIME] | gif.off[`PWCG_G_STAMP1]);
    assign stamp_unit_clk_en[0] = ~(gif.off[`PWCG_G_TIME] | gif.off[`PWCG_G_STAMP0]);
    assign fabric_clk_en        = ~gif.off[`PWCG_G_FABRIC];
    // 25/100 MHz system clocks stop on either host MAC bit
    assign host_mac_sysclk_en   = ~(gif.off[`PWCG_G_HMAC_ALL] | gif.off[`PWCG_G_HMAC_SYS]);
    // receive and transmit clocks stop only on the all-off bit
    assign host_mac_rxtx_clk_en = ~gif.off[`PWCG_G_HMAC_ALL];

    ////////////////////////////////////////////////////////////////////////////
    // control fields; reserved positions have no storage

    // plain read-write control bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_a_wake_en_r      <= 1'b0;
            port_b_wake_en_r      <= 1'b0;
            host_mac_wake_en_r    <= 1'b0;
            wake_pin_buffer_sel_r <= 1'b0;
            wake_pin_style_r      <= 1'b0;
            wake_pin_polarity_r   <= 1'b0;
            wake_pin_en_r         <= 1'b0;
        end else if (wr_ctrl) begin
            port_a_wake_en_r      <= hwdata[`PWCG_B_A_EN];
            port_b_wake_en_r      <= hwdata[`PWCG_B_B_EN];
            host_mac_wake_en_r    <= hwdata[`PWCG_B_HOST_MAC_WAKE_EN];
            wake_pin_buffer_sel_r <= hwdata[`PWCG_B_BUF_SEL];
            wake_pin_style_r      <= hwdata[`PWCG_B_STYLE];
            wake_pin_polarity_r   <= hwdata[`PWCG_B_POL];
            wake_pin_en_r         <= hwdata[`PWCG_B_PIN_EN];
        end
    end

    // port flags: set by the phy level, write-one clear loses to a live event
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_a_wake_flag_r <= 1'b0;
            port_b_wake_flag_r <= 1'b0;
        end else begin
            port_a_wake_flag_r <= phy_a_event |
                (port_a_wake_flag_r & ~(wr_ctrl & hwdata[`PWCG_B_A_FLAG]));
            port_b_wake_flag_r <= phy_b_event |
                (port_b_wake_flag_r & ~(wr_ctrl & hwdata[`PWCG_B_B_FLAG]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, enable and clear

    // enabled wake sources, shared by the interrupt flag and the pin
    assign wake_cond = (port_a_wake_flag_r & port_a_wake_en_r) |
                       (port_b_wake_flag_r & port_b_wake_en_r) |
                       (host_mac_wol_event & host_mac_wake_en_r);

    // events feeding the sticky status bits
    always_comb begin
        irq_set                 = `PWCG_IRQ_RST;
        irq_set[`PWCG_I_WAKE]   = wake_cond;
        irq_set[`PWCG_I_PORT_A] = port_a_wake_flag_r;
        irq_set[`PWCG_I_PORT_B] = port_b_wake_flag_r;
    end

    // sticky status; a set in the same cycle as its clear wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_sts_r <= `PWCG_IRQ_RST;
        end else if (wr_irq_clr) begin
            irq_sts_r <= irq_set | (irq_sts_r & ~hwdata[`PWCG_IRQ_W-1:0]);
        end else begin
            irq_sts_r <= irq_set | irq_sts_r;
        end
    end

    // interrupt enable register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_en_r <= `PWCG_IRQ_RST;
        end else if (wr_irq_en) begin
            irq_en_r <= hwdata[`PWCG_IRQ_W-1:0];
        end
    end

    // level interrupt while any enabled status bit is set
    assign irq = |(irq_sts_r & irq_en_r);

    ////////////////////////////////////////////////////////////////////////////
    // wake pin pulse sequencer

    // one pulse per rise of the wake condition in pulse style
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_st_r  <= pwcg_pkg::pwcg_p_idle;
            pulse_cnt_r <= `PWCG_CNT_ZERO;
        end else if (!wake_pin_style_r || !wake_pin_en_r) begin
            pulse_st_r  <= pwcg_pkg::pwcg_p_idle;
            pulse_cnt_r <= `PWCG_CNT_ZERO;
        end else begin
            case (pulse_st_r)
                pwcg_pkg::pwcg_p_idle: begin
                    if (wake_cond) begin
                        pulse_st_r  <= pwcg_pkg::pwcg_p_pulse;
                        pulse_cnt_r <= `PWCG_CNT_W'(PULSE_CYCLES - 1);
                    end
                end
                pwcg_pkg::pwcg_p_pulse: begin
                    if (pulse_cnt_r == `PWCG_CNT_ZERO) begin
                        pulse_st_r <= pwcg_pkg::pwcg_p_hold;
                    end else begin
                        pulse_cnt_r <= pulse_cnt_r - 1'b1;
                    end
                end
                pwcg_pkg::pwcg_p_hold: begin
                    // wait for the sources to clear before re-arming
                    if (!wake_cond) begin
                        pulse_st_r <= pwcg_pkg::pwcg_p_idle;
                    end
                end
                default: begin
                    pulse_st_r <= pwcg_pkg::pwcg_p_idle;
                end
            endcase
        end
    end

    // pin active in level style while the condition holds, else during the pulse
    assign pin_active = wake_pin_en_r &
        (wake_pin_style_r ? (pulse_st_r == pwcg_pkg::pwcg_p_pulse) : wake_cond);

    // pin drivers: open-drain pulls low only, push-pull follows polarity
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_o_r  <= 1'b0;
            pin_oe_r <= 1'b0;
        end else if (!wake_pin_buffer_sel_r) begin
            pin_o_r  <= 1'b0;
            pin_oe_r <= pin_active;
        end else begin
            pin_o_r  <= ~(pin_active ^ wake_pin_polarity_r);
            pin_oe_r <= 1'b1;
        end
    end

    assign wake_event_pin    = pin_o_r;
    assign wake_event_pin_oe = pin_oe_r;

    // hsize is accepted but only whole-word transfers are expected
    logic unused_hsize;
    assign unused_hsize = |hsize;
endmodule

// ### pwcg_defs.svh
// Purpose: constants for the power clock gate and wake control block
// Assumes: 32-bit AHB-Lite data, word registers, 200 MHz system clock
// Notes:   included by the top, gate interface, arming module and bench of the block
//
// Contract
// - time-unit clock-off bit set stops every clock of the whole time-stamp unit
// - a clock-off bit sets only after two consecutive one-writes; a zero-write restarts
// - three clock-off bits each stop one timestamp unit: 2, 1 and 0
// - fabric clock-off bit set stops all switch fabric clocks
// - host MAC all-off bit stops its 25/100 MHz and receive/transmit clocks
// - host MAC sysclk-off bit stops 25/100 MHz only; receive/transmit keep running
// - all clock-off fields reset to zero, every gated clock enabled
// - each port's PHY event sets that port's status flag, port A and B
// - port flag clears on a one-write only once the PHY event is gone
// - port event with its enable set raises the wake interrupt flag
// - enabled port event also drives the wake pin when pin enabled, in set style
// - host MAC wake with its enable raises the wake flag and drives the pin
// - buffer-select bit: zero open-drain, one push-pull
// - open-drain pin ignores polarity and is always active low
// - style bit: zero continuous level, one single 50 ms pulse
// - pin enable zero never asserts the pin; the interrupt flag still sets
`ifndef PWCG_DEFS_SVH
`define PWCG_DEFS_SVH

// register byte addresses
`define PWCG_CTRL_ADDR    32'h0000_0084
`define PWCG_IRQ_STS_ADDR 32'h0000_0088
`define PWCG_IRQ_EN_ADDR  32'h0000_008C
`define PWCG_IRQ_CLR_ADDR 32'h0000_0090

// control register bit positions
`define PWCG_B_TIME_OFF   25
`define PWCG_B_STAMP2_OFF 24
`define PWCG_B_STAMP1_OFF 23
`define PWCG_B_STAMP0_OFF 22
`define PWCG_B_FABRIC_OFF 20
`define PWCG_B_HMAC_ALL   19
`define PWCG_B_HMAC_SYS   18
`define PWCG_B_B_FLAG     17
`define PWCG_B_A_FLAG     16
`define PWCG_B_B_EN       15
`define PWCG_B_A_EN       14
`define PWCG_B_HOST_MAC_WAKE_EN     9
`define PWCG_B_BUF_SEL    6
`define PWCG_B_STYLE      3
`define PWCG_B_POL        2
`define PWCG_B_PIN_EN     1

// interrupt status bit positions
`define PWCG_I_WAKE       0
`define PWCG_I_PORT_A     1
`define PWCG_I_PORT_B     2
`define PWCG_IRQ_W        3

// gate slots in the arming module
`define PWCG_GATE_N       7
`define PWCG_G_TIME       0
`define PWCG_G_STAMP2     1
`define PWCG_G_STAMP1     2
`define PWCG_G_STAMP0     3
`define PWCG_G_FABRIC     4
`define PWCG_G_HMAC_ALL   5
`define PWCG_G_HMAC_SYS   6

// reset values and bus constants
`define PWCG_GATE_RST     7'h00
`define PWCG_IRQ_RST      3'h0
`define PWCG_WORD_ZERO    32'h0000_0000
`define PWCG_HRESP_OKAY   1'b0

// wake pulse timing
`define PWCG_PULSE_MS     50
`define PWCG_CLK_KHZ      200000
`define PWCG_PULSE_CYCLES (`PWCG_PULSE_MS * `PWCG_CLK_KHZ)
`define PWCG_CNT_W        24
`define PWCG_CNT_ZERO     24'h000000

`endif

// ### pwcg_pkg.sv
// Purpose: shared types of the power clock gate and wake control block
// Assumes: nothing beyond SystemVerilog
// Notes:   constants live in pwcg_defs.svh
package pwcg_pkg;
    // wake pulse sequencer, gray coded along idle, pulse, hold
    typedef enum logic [1:0] {
        pwcg_p_idle  = 2'b00,
        pwcg_p_pulse = 2'b01,
        pwcg_p_hold  = 2'b11
    } pwcg_pulse_t;
endpackage

// ### pwcg_gate_if.sv
// Purpose: carries write strobes and gate states between top and arming module
// Assumes: single clock domain
// Notes:   bit order follows the gate slot constants
`timescale 1ns/1ps
`include "pwcg_defs.svh"
interface pwcg_gate_if;
    logic                    wr;
    logic [`PWCG_GATE_N-1:0] wbits;
    logic [`PWCG_GATE_N-1:0] off;

    modport ctrl (output wr, output wbits, input off);
    modport gate (input wr, input wbits, output off);
endinterface

// ### pwcg_gate_arm.sv
// Purpose: two-write arming of every clock-off bit
// Assumes: wr is a one-cycle strobe per register write
// Notes:   a set bit stays set on further one-writes
`timescale 1ns/1ps
`include "pwcg_defs.svh"
module pwcg_gate_arm (
    // clock and reset
    input wire logic   clk,
    input wire logic   sys_rst,
    // register side
    pwcg_gate_if.gate  g
);
    logic [`PWCG_GATE_N-1:0] armed_r;
    logic [`PWCG_GATE_N-1:0] off_r;

    assign g.off = off_r;

    ////////////////////////////////////////////////////////////////////////////
    // one arming counter per gate bit
    genvar i;
    generate
        for (i = 0; i < `PWCG_GATE_N; i++) begin : gen_arm
            // first one-write arms, second sets, zero-write clears both
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    armed_r[i] <= 1'b0;
                    off_r[i]   <= 1'b0;
                end else if (g.wr) begin
                    if (g.wbits[i]) begin
                        armed_r[i] <= 1'b1;
                        off_r[i]   <= armed_r[i] | off_r[i];
                    end else begin
                        armed_r[i] <= 1'b0;
                        off_r[i]   <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule

// ### pwcg_host_model.sv
// Purpose: host side of the wake event pin, with the board pull-up
// Assumes: one pull-up resistor on the wake line
// Notes:   the host only observes the line level
`timescale 1ns/1ps
module pwcg_host_model (
    // wake pin as driven by the block
    input  wire logic pin_d,
    input  wire logic pin_oe,
    // level seen by the host
    output logic      pin_level
);
    // an undriven line floats up to the pull-up level
    assign pin_level = pin_oe ? pin_d : 1'b1;
endmodule

// ### pwcg_checker.sv
// Purpose: port-level assertions of the power clock gate and wake block
// Assumes: single clock, synchronous active-high reset
// Notes:   bound into pwcg_top
`timescale 1ns/1ps
module pwcg_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // bus and events
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       phy_a_event,
    input wire logic       phy_b_event,
    input wire logic       host_mac_wol_event,
    // outputs under watch
    input wire logic       time_unit_clk_en,
    input wire logic [2:0] stamp_unit_clk_en,
    input wire logic       fabric_clk_en,
    input wire logic       host_mac_sysclk_en,
    input wire logic       host_mac_rxtx_clk_en,
    input wire logic       wake_event_pin,
    input wire logic       wake_event_pin_oe,
    input wire logic       irq
);
    // taken write and any wake source, as seen at the pins
    wire logic aw  = hsel && htrans[1] && hready && hwrite;
    wire logic cau = aw || phy_a_event || phy_b_event || host_mac_wol_event;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence rd_taken_s; hsel && htrans[1] && hready && !hwrite; endsequence
    sequence rd_answer_s; !hreadyout ##1 hreadyout; endsequence

    rst_values_a: assert property ($fell(sys_rst) |-> time_unit_clk_en && stamp_unit_clk_en == 3'h7
        && fabric_clk_en && host_mac_sysclk_en && host_mac_rxtx_clk_en) else $error("enable not high after reset");
    stamp_follow_a: assert property (!time_unit_clk_en |-> stamp_unit_clk_en == 3'h0)
        else $error("stamp clocks run with time unit off");
    mac_pair_a: assert property (!host_mac_rxtx_clk_en |-> !host_mac_sysclk_en)
        else $error("mac system clock runs with all-off");
    od_low_a: assert property (!wake_event_pin_oe |-> !wake_event_pin)
        else $error("pin output high while released");
    time_gate_a: assert property ($changed(time_unit_clk_en) |-> $past(aw) || $past(aw, 2) || $past(aw, 3))
        else $error("time unit gate moved without a write");
    fabric_gate_a: assert property ($changed(fabric_clk_en) |-> $past(aw) || $past(aw, 2) || $past(aw, 3))
        else $error("fabric gate moved without a write");
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
    read_wait_a: assert property (rd_taken_s |=> rd_answer_s) else $error("read wait state wrong");
    irq_cause_a: assert property ($rose(irq) |-> $past(cau) || $past(cau, 2) || $past(cau, 3))
        else $error("irq rose without cause");
endmodule
bind pwcg_top pwcg_checker u_chk (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .phy_a_event(phy_a_event), .phy_b_event(phy_b_event),
    .host_mac_wol_event(host_mac_wol_event), .time_unit_clk_en(time_unit_clk_en),
    .stamp_unit_clk_en(stamp_unit_clk_en), .fabric_clk_en(fabric_clk_en), .host_mac_sysclk_en(host_mac_sysclk_en),
    .host_mac_rxtx_clk_en(host_mac_rxtx_clk_en), .wake_event_pin(wake_event_pin),
    .wake_event_pin_oe(wake_event_pin_oe), .irq(irq));

// ### pwcg_bench.sv
// Purpose: self-checking bench of the power clock gate and wake block
// Assumes: AHB-Lite single word transfers, pulse shortened to 16 cycles
// Notes:   read results are checked by a monitor against a queue
`timescale 1ns/1ps
`include "pwcg_defs.svh"
module pwcg_bench;
    localparam int unsigned PULSE = 16;
    logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, w, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic        phy_a = 1'b0, phy_b = 1'b0, wol = 1'b0;
    logic        hreadyout, hresp, tu, fab, msys, mrx, pin_o, pin_oe, irq, pin_level;
    logic [2:0]  st;
    logic [31:0] expq[$];
    int          miscompares = 0, n_tests = 0, i, cnt;
    logic [6:0]  ens;
    logic [5:0]  gbit[7] = '{6'd25, 6'd24, 6'd23, 6'd22, 6'd20, 6'd19, 6'd18};
    logic [6:0]  gexp[7] = '{7'h07, 7'h5F, 7'h6F, 7'h77, 7'h7B, 7'h7C, 7'h7D};
    assign ens = {tu, st, fab, msys, mrx};

    pwcg_top #(.PULSE_CYCLES(PULSE)) u_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phy_a_event(phy_a), .phy_b_event(phy_b),
        .host_mac_wol_event(wol), .time_unit_clk_en(tu), .stamp_unit_clk_en(st), .fabric_clk_en(fab),
        .host_mac_sysclk_en(msys), .host_mac_rxtx_clk_en(mrx), .wake_event_pin(pin_o),
        .wake_event_pin_oe(pin_oe), .irq(irq));
    pwcg_host_model u_host (.pin_d(pin_o), .pin_oe(pin_oe), .pin_level(pin_level));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counted comparison
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one single transfer, held until hready is sampled high
    task automatic bus(input logic wr_n, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= wr_n;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; rd_dp <= !wr_n;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // lets register and pin updates land
    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    // monitor pops the oldest note when read data return
    always @(posedge clk) begin
        if (rd_dp && hreadyout === 1'b1) chk("rdata", expq.pop_front(), hrdata);
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog for a hung handshake
    initial begin
        #100000;
        miscompares++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(15780));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`PWCG_CTRL_ADDR, 32'h0000_0000);
        chk("clk_en", 32'h0000_007F, ens);
        wr(32'h0000_0100, 32'hFFFF_FFFF);
        rd(32'h0000_0100, 32'h0000_0000);
        rd(`PWCG_CTRL_ADDR, 32'h0000_0000);
        // every gate: arm, break the count, arm twice, release
        for (i = 0; i < 7; i++) begin
            w = 32'h0000_0001 << gbit[i];
            wr(`PWCG_CTRL_ADDR, w); wr(`PWCG_CTRL_ADDR, 32'h0000_0000); wr(`PWCG_CTRL_ADDR, w);
            settle();
            chk("clk_en", 32'h0000_007F, ens);
            wr(`PWCG_CTRL_ADDR, w);
            settle();
            chk("clk_en", {25'h0, gexp[i]}, ens);
            rd(`PWCG_CTRL_ADDR, w);
            wr(`PWCG_CTRL_ADDR, 32'h0000_0000);
            settle();
            chk("clk_en", 32'h0000_007F, ens);
        end
        // random words written twice read back without reserved bits
        for (i = 0; i < 4; i++) begin
            w = $urandom();
            wr(`PWCG_CTRL_ADDR, w); wr(`PWCG_CTRL_ADDR, w);
            rd(`PWCG_CTRL_ADDR, w & 32'h03DC_C24E);
        end
        wr(`PWCG_CTRL_ADDR, 32'h0000_0000);
        wr(`PWCG_IRQ_CLR_ADDR, 32'h0000_0007);
        wr(`PWCG_IRQ_EN_ADDR, 32'h0000_0007);
        // port A event, push-pull active high, level style
        wr(`PWCG_CTRL_ADDR, 32'h0000_C246);
        phy_a <= 1'b1;
        settle();
        chk("irq", 32'h0000_0001, {31'h0, irq});
        chk("pin", 32'h0000_0001, {31'h0, pin_level});
        rd(`PWCG_IRQ_STS_ADDR, 32'h0000_0003);
        wr(`PWCG_CTRL_ADDR, 32'h0001_C246);
        rd(`PWCG_CTRL_ADDR, 32'h0001_C246);
        phy_a <= 1'b0;
        wr(`PWCG_CTRL_ADDR, 32'h0001_C246);
        rd(`PWCG_CTRL_ADDR, 32'h0000_C246);
        wr(`PWCG_IRQ_CLR_ADDR, 32'h0000_0007);
        rd(`PWCG_IRQ_STS_ADDR, 32'h0000_0000);
        settle();
        chk("irq", 32'h0000_0000, {31'h0, irq});
        chk("pin", 32'h0000_0000, {31'h0, pin_level});
        // port B with the pin disabled
        wr(`PWCG_CTRL_ADDR, 32'h0000_C240);
        phy_b <= 1'b1;
        settle();
        rd(`PWCG_IRQ_STS_ADDR, 32'h0000_0005);
        chk("pin", 32'h0000_0001, {31'h0, pin_level});
        phy_b <= 1'b0;
        wr(`PWCG_CTRL_ADDR, 32'h0002_C240);
        wr(`PWCG_IRQ_CLR_ADDR, 32'h0000_0007);
        // host mac wake on an open-drain pin, then masked irq
        wr(`PWCG_CTRL_ADDR, 32'h0000_0206);
        wol <= 1'b1;
        settle();
        chk("pin", 32'h0000_0000, {31'h0, pin_level});
        rd(`PWCG_IRQ_STS_ADDR, 32'h0000_0001);
        wr(`PWCG_IRQ_EN_ADDR, 32'h0000_0000);
        settle();
        chk("irq", 32'h0000_0000, {31'h0, irq});
        wol <= 1'b0;
        wr(`PWCG_IRQ_CLR_ADDR, 32'h0000_0007);
        wr(`PWCG_IRQ_EN_ADDR, 32'h0000_0007);
        settle();
        chk("pin", 32'h0000_0001, {31'h0, pin_level});
        // pulse style lasts exactly the pulse count
        wr(`PWCG_CTRL_ADDR, 32'h0000_024E);
        settle();
        wol <= 1'b1;
        cnt = 0;
        repeat (48) begin
            @(posedge clk);
            if (pin_level === 1'b1) cnt++;
        end
        chk("pulse", PULSE, cnt);
        wol <= 1'b0;
        wr(`PWCG_IRQ_CLR_ADDR, 32'h0000_0007);
        settle();
        chk("queue", 32'h0000_0000, expq.size());
        final_report();
    end
endmodule
